// ==== hw/backup_pin_control.v ====
// Pin function selection for the three backup-domain pins, with AXI4-Lite registers
//
// Overview of operation
// - Alarm enabled owns shared pin; value bit picks OD/PP
// - Shared pin priority: alarm, calib, inputs, forced, GPIO
// - Unclaimed shared pin with force: push-pull at value
// - Shared pin forced state held through Standby
// - Output, timestamp, tamper share one physical pin
// - Calib enable drives 512 Hz or 1 Hz
// - Two-bit select: alarm A, B or wakeup
// - Combined output carries calibration or alarm only
// - Unused oscillator pins forceable to push-pull outputs
// - Oscillator pin forced states held through Standby
`include "backup_pin_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module backup_pin_control (
  input  wire        CLOCK_IN,          // 10 MHz system clock
  input  wire        SRST_IN,           // Synchronous reset, active high
  input  wire        LS_TICK_IN,        // Low-speed clock enable pulse, 32.768 kHz
  input  wire        ALARM_A_IN,        // Alarm A flag, same clock
  input  wire        ALARM_B_IN,        // Alarm B flag, same clock
  input  wire        WAKEUP_IN,         // Periodic wakeup flag, same clock
  input  wire        STANDBY_IN,        // Device in Standby, same clock
  input  wire        SHARED_PIN_IN,     // Shared pin level, asynchronous
  output reg         SHARED_PIN_OUT,    // Shared pin drive level
  output reg         SHARED_PIN_OE_OUT, // Shared pin output enable
  output reg         OSC_IN_PIN_OUT,    // Oscillator input pin drive level
  output reg         OSC_IN_PIN_OE_OUT, // Oscillator input pin output enable
  output reg         OSC_OUT_PIN_OUT,   // Oscillator output pin drive level
  output reg         OSC_OUT_PIN_OE_OUT,// Oscillator output pin output enable
  output reg         OSC_ACTIVE_OUT,    // Pins handed to the oscillator
  output reg         TIMESTAMP_OUT,     // Timestamp input level to clock unit
  output reg         TAMPER_ONE_OUT,    // Tamper one input level to clock unit
  input  wire [11:0] AWADDR,            // Write address
  input  wire        AWVALID,           // Write address valid
  output reg         AWREADY,           // Write address ready
  input  wire [31:0] WDATA,             // Write data
  input  wire [3:0]  WSTRB,             // Write byte strobes
  input  wire        WVALID,            // Write data valid
  output reg         WREADY,            // Write data ready
  output reg  [1:0]  BRESP,             // Write response
  output reg         BVALID,            // Write response valid
  input  wire        BREADY,            // Write response ready
  input  wire [11:0] ARADDR,            // Read address
  input  wire        ARVALID,           // Read address valid
  output reg         ARREADY,           // Read address ready
  output reg  [31:0] RDATA,             // Read data
  output reg  [1:0]  RRESP,             // Read response
  output reg         RVALID,            // Read data valid
  input  wire        RREADY             // Read data ready
);

  parameter CAL_FAST_HALF = `CAL_FAST_HALF;
  parameter CAL_SLOW_HALF = `CAL_SLOW_HALF;

  localparam [1:0] RESP_OKAY   = 2'h0;
  localparam [1:0] RESP_SLVERR = 2'h2;

  function valid_addr;
    input [11:0] a;
    begin
      valid_addr = (a == `REG_PIN_CTRL) || (a == `REG_OUT_CTRL) ||
                   (a == `REG_INPUT_CTRL) || (a == `REG_PIN_STATUS);
    end
  endfunction

  // Forced push-pull drive of a pin the oscillator does not hold: {enable, level}
  function [1:0] pin_drive;
    input owned;
    input force_out;
    input value;
    begin
      if (owned) begin
        pin_drive = 2'b00;
      end else begin
        pin_drive = {force_out, force_out & value};
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [5:0]  pin_ctrl_r;
  reg [6:0]  out_ctrl_r;
  reg [1:0]  input_ctrl_r;
  reg [11:0] wr_addr_r;
  reg        aw_held_r;
  reg [31:0] wr_data_r;
  reg [3:0]  wr_strb_r;
  reg        w_held_r;
  reg        pin_meta_r;
  reg        pin_sync_r;
  reg [14:0] cal_count_r;
  reg        cal_clock_r;
  reg [2:0]  shared_fn_r;

  wire shared_pin_force_out  = pin_ctrl_r[`SHARED_FORCE_BIT];
  wire shared_pin_value  = pin_ctrl_r[`SHARED_VALUE_BIT];
  wire osc_in_pin_force_out  = pin_ctrl_r[`OSCIN_FORCE_BIT];
  wire osc_in_pin_value      = pin_ctrl_r[`OSCIN_VALUE_BIT];
  wire osc_out_pin_force_out = pin_ctrl_r[`OSCOUT_FORCE_BIT];
  wire osc_out_pin_value     = pin_ctrl_r[`OSCOUT_VALUE_BIT];
  wire calib_out_enable      = out_ctrl_r[`CALIB_EN_BIT];
  wire calib_slow            = out_ctrl_r[`CALIB_SEL_BIT];
  wire [1:0] alarm_out_select = out_ctrl_r[`ALARM_SEL_HI:`ALARM_SEL_LO];
  wire alarm_polarity        = out_ctrl_r[`ALARM_POL_BIT];
  wire lowspeed_osc_on       = out_ctrl_r[`LSE_ON_BIT];
  wire lowspeed_osc_bypass   = out_ctrl_r[`LSE_BYP_BIT];
  wire tamper_enable         = input_ctrl_r[`TAMPER_EN_BIT];
  wire stamp_enable          = input_ctrl_r[`STAMP_EN_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side: address and data taken in either order
  wire aw_have = aw_held_r | (AWVALID & AWREADY);
  wire w_have  = w_held_r | (WVALID & WREADY);
  wire [11:0] wa = aw_held_r ? wr_addr_r : AWADDR;
  wire [31:0] wd = w_held_r ? wr_data_r : WDATA;
  wire [3:0]  ws = w_held_r ? wr_strb_r : WSTRB;
  wire do_write = aw_have & w_have & ~BVALID;

  always @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      AWREADY      <= 1'b0;
      WREADY       <= 1'b0;
      BVALID       <= 1'b0;
      BRESP        <= RESP_OKAY;
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      wr_addr_r    <= 12'h000;
      wr_data_r    <= 32'h00000000;
      wr_strb_r    <= 4'h0;
      pin_ctrl_r   <= `PIN_CTRL_RESET;
      out_ctrl_r   <= `OUT_CTRL_RESET;
      input_ctrl_r <= `INPUT_CTRL_RESET;
    end else begin
      AWREADY <= ~aw_have & ~AWREADY & ~BVALID;
      WREADY  <= ~w_have & ~WREADY & ~BVALID;
      if (AWVALID & AWREADY) begin
        wr_addr_r <= AWADDR;
        aw_held_r <= 1'b1;
      end
      if (WVALID & WREADY) begin
        wr_data_r <= WDATA;
        wr_strb_r <= WSTRB;
        w_held_r  <= 1'b1;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        AWREADY   <= 1'b0;
        WREADY    <= 1'b0;
        BVALID    <= 1'b1;
        BRESP     <= valid_addr(wa) ? RESP_OKAY : RESP_SLVERR;
        // Only byte 0 carries fields; other lanes are ignored
        if (ws[0]) begin
          case (wa)
            `REG_PIN_CTRL:   pin_ctrl_r   <= wd[5:0];
            `REG_OUT_CTRL:   out_ctrl_r   <= wd[6:0];
            `REG_INPUT_CTRL: input_ctrl_r <= wd[1:0];
            default: ;
          endcase
        end
      end else if (BVALID & BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read side
  reg [31:0] rd_nxt;
  always @* begin
    case (ARADDR)
      `REG_PIN_CTRL:   rd_nxt = {26'h0, pin_ctrl_r};
      `REG_OUT_CTRL:   rd_nxt = {25'h0, out_ctrl_r};
      `REG_INPUT_CTRL: rd_nxt = {30'h0, input_ctrl_r};
      `REG_PIN_STATUS: rd_nxt = {24'h0, OSC_ACTIVE_OUT, pin_sync_r, SHARED_PIN_OE_OUT,
                                 SHARED_PIN_OUT, 1'b0, shared_fn_r};
      default:         rd_nxt = 32'h00000000;
    endcase
  end

  always @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= RESP_OKAY;
    end else begin
      ARREADY <= ~ARREADY & ~RVALID & ARVALID;
      if (ARVALID & ARREADY) begin
        RVALID <= 1'b1;
        RRESP  <= valid_addr(ARADDR) ? RESP_OKAY : RESP_SLVERR;
        RDATA  <= rd_nxt;
      end else if (RVALID & RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Calibration clock divided from the low-speed tick
  wire [14:0] cal_half = calib_slow ? CAL_SLOW_HALF[14:0] : CAL_FAST_HALF[14:0];

  always @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      cal_count_r <= 15'h0000;
      cal_clock_r <= 1'b0;
    end else if (!calib_out_enable) begin
      cal_count_r <= 15'h0000;
      cal_clock_r <= 1'b0;
    end else if (LS_TICK_IN) begin
      if (cal_count_r >= cal_half - 15'h0001) begin
        cal_count_r <= 15'h0000;
        cal_clock_r <= ~cal_clock_r;
      end else begin
        cal_count_r <= cal_count_r + 15'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared pin selection
  reg alarm_src;
  always @* begin
    case (alarm_out_select)
      `ALSEL_ALARM_A: alarm_src = ALARM_A_IN;
      `ALSEL_ALARM_B: alarm_src = ALARM_B_IN;
      `ALSEL_WAKEUP:  alarm_src = WAKEUP_IN;
      default:        alarm_src = 1'b0;
    endcase
  end

  wire alarm_enabled = (alarm_out_select != `ALSEL_OFF);
  wire alarm_level   = alarm_src ^ alarm_polarity;
  wire inputs_on     = tamper_enable | stamp_enable;
  wire osc_owns      = lowspeed_osc_on;

  reg [2:0] fn_nxt;
  reg       shared_out_nxt;
  reg       shared_oe_nxt;
  always @* begin
    fn_nxt         = `FN_GPIO;
    shared_out_nxt = 1'b0;
    shared_oe_nxt  = 1'b0;
    if (alarm_enabled) begin
      fn_nxt = `FN_ALARM;
      if (shared_pin_value) begin
        shared_out_nxt = alarm_level;
        shared_oe_nxt  = 1'b1;
      end else begin
        // Open drain: drive only the low level
        shared_out_nxt = 1'b0;
        shared_oe_nxt  = ~alarm_level;
      end
    end else if (calib_out_enable) begin
      fn_nxt         = `FN_CALIB;
      shared_out_nxt = cal_clock_r;
      shared_oe_nxt  = 1'b1;
    end else if (inputs_on) begin
      fn_nxt = `FN_INPUT;
    end else if (shared_pin_force_out) begin
      fn_nxt         = `FN_FORCED;
      shared_out_nxt = shared_pin_value;
      shared_oe_nxt  = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator pins and input routing, next values
  // In bypass the output pin is free for forcing
  wire osc_out_owned = osc_owns & ~lowspeed_osc_bypass;
  reg [1:0] osc_in_nxt;
  reg [1:0] osc_out_nxt;
  reg       stamp_nxt;
  reg       tamper_nxt;
  always @* begin
    osc_in_nxt  = pin_drive(osc_owns, osc_in_pin_force_out, osc_in_pin_value);
    osc_out_nxt = pin_drive(osc_out_owned, osc_out_pin_force_out, osc_out_pin_value);
    // Inputs read from the same pin, gated by their enables
    stamp_nxt   = (fn_nxt == `FN_INPUT) & stamp_enable & pin_sync_r;
    tamper_nxt  = (fn_nxt == `FN_INPUT) & tamper_enable & pin_sync_r;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin outputs; control bits live in the write-side block, so Standby leaves them untouched
  always @(posedge CLOCK_IN) begin
    if (SRST_IN) begin
      pin_meta_r         <= 1'b0;
      pin_sync_r         <= 1'b0;
      shared_fn_r        <= `FN_GPIO;
      SHARED_PIN_OUT     <= 1'b0;
      SHARED_PIN_OE_OUT  <= 1'b0;
      OSC_IN_PIN_OUT     <= 1'b0;
      OSC_IN_PIN_OE_OUT  <= 1'b0;
      OSC_OUT_PIN_OUT    <= 1'b0;
      OSC_OUT_PIN_OE_OUT <= 1'b0;
      OSC_ACTIVE_OUT     <= 1'b0;
      TIMESTAMP_OUT      <= 1'b0;
      TAMPER_ONE_OUT     <= 1'b0;
    end else begin
      pin_meta_r  <= SHARED_PIN_IN;
      pin_sync_r  <= pin_meta_r;
      shared_fn_r <= fn_nxt;
      // Forced level frozen in Standby; a higher function still takes the pin at once
      if (STANDBY_IN && shared_fn_r == `FN_FORCED && fn_nxt == `FN_FORCED) begin
        SHARED_PIN_OUT    <= SHARED_PIN_OUT;
        SHARED_PIN_OE_OUT <= SHARED_PIN_OE_OUT;
      end else begin
        SHARED_PIN_OUT    <= shared_out_nxt;
        SHARED_PIN_OE_OUT <= shared_oe_nxt;
      end
      TIMESTAMP_OUT      <= stamp_nxt;
      TAMPER_ONE_OUT     <= tamper_nxt;
      OSC_ACTIVE_OUT     <= osc_owns;
      // Forced oscillator pins follow their own bits, which Standby leaves alone
      OSC_IN_PIN_OE_OUT  <= osc_in_nxt[1];
      OSC_IN_PIN_OUT     <= osc_in_nxt[0];
      OSC_OUT_PIN_OE_OUT <= osc_out_nxt[1];
      OSC_OUT_PIN_OUT    <= osc_out_nxt[0];
    end
  end

endmodule // backup_pin_control

`default_nettype wire

// ==== hw/backup_pin_defs.vh ====
// Constants for the backup-domain pin selection block
`ifndef BACKUP_PIN_DEFS_VH
`define BACKUP_PIN_DEFS_VH

// Register byte offsets
`define REG_PIN_CTRL      12'h000
`define REG_OUT_CTRL      12'h004
`define REG_INPUT_CTRL    12'h008
`define REG_PIN_STATUS    12'h00C

// Pin control register fields
`define SHARED_FORCE_BIT  0
`define SHARED_VALUE_BIT  1
`define OSCIN_FORCE_BIT   2
`define OSCIN_VALUE_BIT   3
`define OSCOUT_FORCE_BIT  4
`define OSCOUT_VALUE_BIT  5
`define PIN_CTRL_RESET    6'h00

// Output control register fields
`define CALIB_EN_BIT      0
`define CALIB_SEL_BIT     1
`define ALARM_SEL_LO      2
`define ALARM_SEL_HI      3
`define ALARM_POL_BIT     4
`define LSE_ON_BIT        5
`define LSE_BYP_BIT       6
`define OUT_CTRL_RESET    7'h00

// Input control register fields
`define TAMPER_EN_BIT     0
`define STAMP_EN_BIT      1
`define INPUT_CTRL_RESET  2'h0

// Alarm output sources
`define ALSEL_OFF         2'h0
`define ALSEL_ALARM_A     2'h1
`define ALSEL_ALARM_B     2'h2
`define ALSEL_WAKEUP      2'h3

// Shared pin functions, shown in status
`define FN_ALARM          3'h0
`define FN_CALIB          3'h1
`define FN_INPUT          3'h2
`define FN_FORCED         3'h3
`define FN_GPIO           3'h4

// Calibration clock timing at a 32.768 kHz low-speed clock
`define LS_CLOCK_HZ       32768
`define CAL_FAST_HZ       512
`define CAL_SLOW_HZ       1
`define CAL_FAST_HALF     (`LS_CLOCK_HZ / (2 * `CAL_FAST_HZ))
`define CAL_SLOW_HALF     (`LS_CLOCK_HZ / (2 * `CAL_SLOW_HZ))

`endif

// ==== verif/backup_pin_properties.sv ====
// Port-level properties of the backup pin selection block
`timescale 1ns/1ps
`default_nettype none
module backup_pin_properties #(
  parameter CAL_FAST_HALF = 2,
  parameter CAL_SLOW_HALF = 4
) (
  input wire logic        CLOCK_IN, SRST_IN,
  input wire logic        SHARED_PIN_OE_OUT, OSC_IN_PIN_OE_OUT, OSC_ACTIVE_OUT, TIMESTAMP_OUT, TAMPER_ONE_OUT,
  input wire logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY,
  input wire logic [1:0]  BRESP,
  input wire logic [31:0] RDATA
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (SRST_IN);
  a_reset_quiet: assert property (disable iff (1'b0) SRST_IN |=> !SHARED_PIN_OE_OUT && !OSC_ACTIVE_OUT && !BVALID)
    else $error("outputs active after reset");
  a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |=> BVALID && !AWREADY && !WREADY)
    else $error("write response missing");
  a_resp_stable: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  a_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read data missing");
  a_rdata_stable: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  a_busy_refuse: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("request taken while response pending");
  a_osc_in_yield: assert property (OSC_ACTIVE_OUT |-> !OSC_IN_PIN_OE_OUT)
    else $error("oscillator input pin driven");
  a_input_floats: assert property (TIMESTAMP_OUT || TAMPER_ONE_OUT |-> !SHARED_PIN_OE_OUT)
    else $error("shared pin driven in input function");
endmodule // backup_pin_properties
bind backup_pin_control backup_pin_properties #(.CAL_FAST_HALF(CAL_FAST_HALF), .CAL_SLOW_HALF(CAL_SLOW_HALF))
  backup_pin_properties_i (.CLOCK_IN(CLOCK_IN), .SRST_IN(SRST_IN), .SHARED_PIN_OE_OUT(SHARED_PIN_OE_OUT),
  .OSC_IN_PIN_OE_OUT(OSC_IN_PIN_OE_OUT), .OSC_ACTIVE_OUT(OSC_ACTIVE_OUT), .TIMESTAMP_OUT(TIMESTAMP_OUT),
  .TAMPER_ONE_OUT(TAMPER_ONE_OUT), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
  .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY),
  .BRESP(BRESP), .RDATA(RDATA));
`default_nettype wire

// ==== verif/board_pins.sv ====
// Board circuitry on the shared backup pin
`timescale 1ns/1ps
`default_nettype none
module board_pins (
  input  wire logic oe_in,  // Device drives the pin
  input  wire logic out_in, // Device drive level
  input  wire logic ext_in, // Level of the board source
  output wire logic pin_out // Resolved pin level
);
  // Board source is weak: the device wins whenever it drives
  assign pin_out = oe_in ? out_in : ext_in;
endmodule // board_pins
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench: random pin configurations against a reference model
`timescale 1ns/1ps
`default_nettype none
`include "backup_pin_defs.vh"
module tb;
  localparam int FH = 2;
  localparam int SH = 4;
  logic        clk = 1'b0, srst = 1'b1, tick = 1'b0, al_a = 1'b0, al_b = 1'b0, wk = 1'b0;
  logic        stby = 1'b0, ext_lv = 1'b0, pin, prev;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, sh_out, sh_oe, oi_out, oi_oe, oo_out, oo_oe;
  logic        osc_act, ts, tp;
  logic [1:0]  bresp, rresp, rs, i;
  logic [2:0]  tcnt = 3'h0;
  logic [3:0]  wstrb = 4'hF;
  logic [5:0]  p;
  logic [6:0]  o;
  logic [4:0]  e;
  int          fails = 0, n_tests = 0, seed = 48, tog;
  ////////////////////////////////////////////////////////////////////////////////
  backup_pin_control #(.CAL_FAST_HALF(FH), .CAL_SLOW_HALF(SH)) backup_pin_control_i (
    .CLOCK_IN(clk), .SRST_IN(srst), .LS_TICK_IN(tick), .ALARM_A_IN(al_a), .ALARM_B_IN(al_b),
    .WAKEUP_IN(wk), .STANDBY_IN(stby), .SHARED_PIN_IN(pin), .SHARED_PIN_OUT(sh_out),
    .SHARED_PIN_OE_OUT(sh_oe), .OSC_IN_PIN_OUT(oi_out), .OSC_IN_PIN_OE_OUT(oi_oe),
    .OSC_OUT_PIN_OUT(oo_out), .OSC_OUT_PIN_OE_OUT(oo_oe), .OSC_ACTIVE_OUT(osc_act),
    .TIMESTAMP_OUT(ts), .TAMPER_ONE_OUT(tp), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
  board_pins board_pins_i (.oe_in(sh_oe), .out_in(sh_out), .ext_in(ext_lv), .pin_out(pin));
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #50 clk = ~clk;
  // Low-speed tick far faster than real so calibration periods stay short
  always @(posedge clk) begin
    tcnt <= tcnt + 3'h1;
    tick <= &tcnt;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // Returns {function, enable, level}; calibration level is checked by counting edges
  function automatic logic [4:0] model(input logic [5:0] pc, input logic [6:0] oc, input logic [1:0] ic);
    logic lv;
    lv = (oc[3:2] == `ALSEL_ALARM_A ? al_a : oc[3:2] == `ALSEL_ALARM_B ? al_b : wk) ^ oc[4];
    if (oc[3:2] != `ALSEL_OFF) return {`FN_ALARM, pc[1] | !lv, pc[1] & lv};
    if (oc[0]) return {`FN_CALIB, 2'b10};
    if (ic != 2'h0) return {`FN_INPUT, 2'b00};
    if (pc[0]) return {`FN_FORCED, 1'b1, pc[1]};
    return {`FN_GPIO, 2'b00};
  endfunction
  task automatic chk_pins;
    e = model(p, o, i);
    cmp(sh_oe, e[1]);
    if (e[1] && e[4:2] != `FN_CALIB) cmp(sh_out, e[0]);
    cmp({oi_oe, oi_oe & oi_out}, o[5] ? 2'b00 : {p[2], p[2] & p[3]});
    cmp({oo_oe, oo_oe & oo_out}, (o[5] & !o[6]) | !p[4] ? 2'b00 : {1'b1, p[5]});
    cmp(osc_act, o[5]);
    cmp({ts, tp}, e[4:2] == `FN_INPUT ? {i[1] & ext_lv, i[0] & ext_lv} : 2'b00);
    axr(`REG_PIN_STATUS, rd, rs);
    cmp(rd[2:0], e[4:2]);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(20000 * 100);
    fails++;
    wrap_up;
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int k = 0; k < 3; k++) begin
      axr(12'(4 * k), rd, rs);
      cmp(rd, 32'h0);
    end
    axr(`REG_PIN_STATUS, rd, rs);
    cmp(rd[2:0], `FN_GPIO);
    axw(12'h010, 32'hFF, rs);
    cmp(rs, 2'b10);
    axr(12'h010, rd, rs);
    cmp({rd[29:0], rs}, 32'h2);
    $display("reset and map done");
    for (int k = 0; k < 40; k++) begin
      p = $random(seed);
      o = $random(seed);
      i = $random(seed);
      // Half the passes clear alarm and calibration so lower priorities show
      if (k[0]) o = o & 7'h72;
      ext_lv <= $random(seed);
      {al_a, al_b, wk} <= $random(seed);
      axw(`REG_PIN_CTRL, p, rs);
      axw(`REG_OUT_CTRL, o, rs);
      axw(`REG_INPUT_CTRL, i, rs);
      repeat (5) @(posedge clk);
      chk_pins;
      axr(`REG_OUT_CTRL, rd, rs);
      cmp(rd, o);
    end
    $display("random configurations done");
    axw(`REG_OUT_CTRL, 32'h0, rs);
    axw(`REG_INPUT_CTRL, 32'h0, rs);
    axw(`REG_PIN_CTRL, 32'h3F, rs);
    stby <= 1'b1;
    axw(`REG_PIN_CTRL, 32'h15, rs);
    repeat (3) @(posedge clk);
    cmp({sh_oe, sh_out, oi_oe, oo_oe}, 4'hF);
    stby <= 1'b0;
    repeat (3) @(posedge clk);
    cmp({sh_oe, sh_out}, 2'b10);
    $display("standby hold done");
    // Byte lane 0 off: the write must change nothing
    wstrb <= 4'hE;
    axw(`REG_PIN_CTRL, 32'h0, rs);
    wstrb <= 4'hF;
    axr(`REG_PIN_CTRL, rd, rs);
    cmp(rd, 32'h15);
    cmp({sh_oe, sh_out, oi_oe, oo_oe}, 4'hB);
    $display("strobe mask done");
    for (int s = 0; s < 2; s++) begin
      axw(`REG_OUT_CTRL, 32'h1 | (s << 1), rs);
      tog = 0;
      prev = sh_out;
      repeat (256) begin
        @(posedge clk);
        tog += (sh_out !== prev);
        prev = sh_out;
      end
      cmp(sh_oe, 1'b1);
      cmp(tog inside {[32 / (s ? SH : FH) - 1 : 32 / (s ? SH : FH) + 1]}, 1'b1);
    end
    $display("calibration clock done");
    wrap_up;
  end
endmodule // tb
`default_nettype wire
